// [ircc_regs.vh]
`ifndef IRCC_REGS_VH
`define IRCC_REGS_VH
`define IRCC_IDX_PWR 8'h02
`define IRCC_IDX_ID 8'h08
`define IRCC_IDX_DMA 8'ha2
`define IRCC_IDX_CTL 8'ha3
`define IRCC_IDX_UH 8'ha4
`define IRCC_IDX_UL 8'ha5
`define IRCC_IDX_FH 8'ha6
`define IRCC_IDX_FL 8'ha7
`define IRCC_IDX_STAT 8'hb0
`define IRCC_IDX_EVT 8'hb1
`define IRCC_PWR_RST 8'h02
`define IRCC_PD_BIT 0
`define IRCC_PDEN_BIT 1
`define IRCC_LOCK_BIT 6
`define IRCC_IREN_BIT 0
`define IRCC_SHSEL_BIT 2
`define IRCC_ADV_BIT 3
`define IRCC_LVL_BIT 4
`define IRCC_WIN_BIT 5
`define IRCC_SEL_IRQ3 3'h0
`define IRCC_SEL_IRQ4 3'h1
`define IRCC_SEL_UPIN 3'h2
`define IRCC_SEL_FPIN 3'h3
`define IRCC_DMA_NONE 3'h4
`define IRCC_PULSE_MIN_US 500
`define IRCC_PULSE_MAX_US 1000
`define IRCC_CLK_MHZ 10
`define IRCC_RESP_OKAY 2'h0
`define IRCC_RESP_SLVERR 2'h2
`endif

// [ircc_pulse.v]
`timescale 1ns/1ps
`include "ircc_regs.vh"
module ircc_pulse #(
  parameter CNT_W = 16,
  parameter [15:0] PULSE_CYC = 16'd7500
) (
  input wire sys_clk,
  input wire rstn,
  input wire req,
  output wire pulse
);
  reg req_d_ff;
  reg [CNT_W-1:0] cnt_ff;
  reg [CNT_W-1:0] nxt_cnt;
  // New edge during a pulse is merged into it: avoids stretching past the ceiling
  always @* begin
    nxt_cnt = cnt_ff;
    if (cnt_ff != {CNT_W{1'b0}})
      nxt_cnt = cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
    else if (req && !req_d_ff)
      nxt_cnt = PULSE_CYC[CNT_W-1:0];
  end
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req_d_ff <= 1'b0;
      cnt_ff <= {CNT_W{1'b0}};
    end else begin
      req_d_ff <= req;
      cnt_ff <= nxt_cnt;
    end
  end
  assign pulse = (cnt_ff != {CNT_W{1'b0}});
endmodule

// [ircc_cfg.v]
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ircc_regs.vh"
module ircc_cfg #(
  // Identity codes are arbitrary values
  parameter [7:0] ID_DMA = 8'h5a,
  parameter [7:0] ID_SHM = 8'h5b,
  parameter [7:0] ADDR_W = 8'd12
) (
  input wire sys_clk,
  input wire rstn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire shared_memory_mode,
  input wire power_down_input_n,
  input wire uart_irq_req,
  input wire fast_irq_req,
  input wire [19:0] host_mem_addr,
  output wire [3:0] irq_out_n,
  output wire uart_interrupt_pin,
  output wire infrared_interrupt_pin,
  output wire [2:0] internal_dma_request_one_sel,
  output wire [2:0] internal_dma_request_two_sel,
  output wire mem_window_hit,
  output wire [15:0] uart_base_addr,
  output wire [15:0] fast_base_addr,
  output wire power_down,
  output wire uart_clk_en,
  output wire fast_clk_en,
  output wire transceiver_off_output
);
  localparam integer PULSE_MIN_CYC = `IRCC_PULSE_MIN_US * `IRCC_CLK_MHZ;
  localparam integer PULSE_MAX_CYC = `IRCC_PULSE_MAX_US * `IRCC_CLK_MHZ;
  localparam integer PULSE_MID_CYC = (PULSE_MIN_CYC + PULSE_MAX_CYC) / 2;
  // Midpoint leaves a quarter millisecond of margin on either side
  localparam [15:0] PULSE_CYC = PULSE_MID_CYC[15:0];
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WRITE = 3'b010;
  localparam [2:0] ST_RESP = 3'b100;

  // Pin synchronisers
  reg [1:0] pd_sync_ff;
  reg [1:0] smm_sync_ff;
  reg [1:0] uq_sync_ff;
  reg [1:0] fq_sync_ff;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pd_sync_ff <= 2'b11;
      smm_sync_ff <= 2'b00;
      uq_sync_ff <= 2'b00;
      fq_sync_ff <= 2'b00;
    end else begin
      pd_sync_ff <= {pd_sync_ff[0], power_down_input_n};
      smm_sync_ff <= {smm_sync_ff[0], shared_memory_mode};
      uq_sync_ff <= {uq_sync_ff[0], uart_irq_req};
      fq_sync_ff <= {fq_sync_ff[0], fast_irq_req};
    end
  end
  wire pd_pin_n = pd_sync_ff[1];
  wire shm = smm_sync_ff[1];
  wire uart_req = uq_sync_ff[1];
  wire fast_req = fq_sync_ff[1];

  reg [7:0] pwr_ff;
  reg [7:0] dma_ff;
  reg [7:0] wbase_ff;
  reg [7:0] ctl_ff;
  reg [7:0] uh_ff;
  reg [7:0] ul_ff;
  reg [7:0] fh_ff;
  reg [7:0] fl_ff;
  reg [2:0] wst_ff;
  reg [7:0] waddr_ff;
  reg aw_got_ff;
  reg w_got_ff;
  reg werr_ff;
  reg [7:0] wdata_ff;
  reg wstb_ff;
  reg rvalid_ff;
  reg rerr_ff;
  reg [7:0] rdata_ff;

  function [7:0] idx_of;
    input [11:0] a;
    begin
      idx_of = a[9:2];
    end
  endfunction

  function known_idx;
    input [7:0] i;
    begin
      case (i)
        `IRCC_IDX_PWR, `IRCC_IDX_ID, `IRCC_IDX_DMA, `IRCC_IDX_CTL, `IRCC_IDX_UH,
        `IRCC_IDX_UL, `IRCC_IDX_FH, `IRCC_IDX_FL, `IRCC_IDX_STAT: known_idx = 1'b1;
        default: known_idx = 1'b0;
      endcase
    end
  endfunction

  // Write channel: address and data taken in either order
  assign s_axi_awready = (wst_ff != ST_RESP) && !aw_got_ff;
  assign s_axi_wready = (wst_ff != ST_RESP) && !w_got_ff;
  assign s_axi_bvalid = (wst_ff == ST_RESP);
  assign s_axi_bresp = werr_ff ? `IRCC_RESP_SLVERR : `IRCC_RESP_OKAY;

  wire aw_now = s_axi_awvalid && s_axi_awready;
  wire w_now = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_got_ff || aw_now;
  wire w_have = w_got_ff || w_now;
  wire [7:0] aw_idx = aw_now ? idx_of(s_axi_awaddr) : waddr_ff;
  wire [7:0] w_byte = w_now ? s_axi_wdata[7:0] : wdata_ff;
  wire w_lane = w_now ? s_axi_wstrb[0] : wstb_ff;
  wire aw_ok = aw_now ? (s_axi_awaddr[11:10] == 2'b00) : 1'b1;
  wire locked = pwr_ff[`IRCC_LOCK_BIT];
  wire do_write = (wst_ff != ST_RESP) && aw_have && w_have;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wst_ff <= ST_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wstb_ff <= 1'b0;
      werr_ff <= 1'b0;
    end else begin
      case (wst_ff)
        ST_IDLE, ST_WRITE: begin
          if (aw_now) begin
            aw_got_ff <= 1'b1;
            waddr_ff <= aw_ok ? idx_of(s_axi_awaddr) : 8'hff;
          end
          if (w_now) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata[7:0];
            wstb_ff <= s_axi_wstrb[0];
          end
          if (do_write) begin
            wst_ff <= ST_RESP;
            werr_ff <= !aw_ok || !known_idx(aw_idx);
          end else if (aw_now || w_now) begin
            wst_ff <= ST_WRITE;
          end
        end
        ST_RESP: begin
          if (s_axi_bready) begin
            wst_ff <= ST_IDLE;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
          end
        end
        default: wst_ff <= ST_IDLE;
      endcase
    end
  end

  // Locked writes still answer OKAY but change nothing
  wire wr_en = do_write && aw_ok && w_lane && !locked;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pwr_ff <= `IRCC_PWR_RST;
      dma_ff <= {1'b0, `IRCC_DMA_NONE, 1'b0, `IRCC_DMA_NONE};
      wbase_ff <= 8'h00;
      ctl_ff <= 8'h00;
      uh_ff <= 8'h00;
      ul_ff <= 8'h00;
      fh_ff <= 8'h00;
      fl_ff <= 8'h00;
    end else if (wr_en) begin
      case (aw_idx)
        `IRCC_IDX_PWR:
          pwr_ff <= {pwr_ff[7] | w_byte[7], w_byte[6:4], 1'b0, w_byte[2:0]};
        `IRCC_IDX_DMA: begin
          // Same index holds two registers, steered by the mode pin
          if (shm)
            wbase_ff <= {w_byte[7:1], 1'b0};
          else
            dma_ff <= {1'b0, w_byte[6:4], 1'b0, w_byte[2:0]};
        end
        `IRCC_IDX_CTL: ctl_ff <= {2'b00, w_byte[5:2], 1'b0, w_byte[0]};
        `IRCC_IDX_UH: uh_ff <= w_byte;
        `IRCC_IDX_UL: ul_ff <= w_byte;
        `IRCC_IDX_FH: fh_ff <= w_byte;
        `IRCC_IDX_FL: fl_ff <= w_byte;
        default: pwr_ff <= pwr_ff;
      endcase
    end
  end

  // Power control
  wire pd_en = pwr_ff[`IRCC_PDEN_BIT];
  assign power_down = pd_en && (pwr_ff[`IRCC_PD_BIT] || !pd_pin_n);
  wire ir_en = ctl_ff[`IRCC_IREN_BIT];
  assign transceiver_off_output = !ir_en || power_down;
  // Conservation gates the clock of a subsystem that is idle
  assign fast_clk_en = ir_en && !power_down;
  assign uart_clk_en = !power_down && !(pd_en && (uh_ff == 8'h00) && (ul_ff[7:3] == 5'h00));

  // Shared memory mode frees both request lines, so no channel is driven
  function [2:0] dma_sel;
    input mode;
    input [2:0] code;
    begin
      dma_sel = mode ? `IRCC_DMA_NONE : code;
    end
  endfunction

  function [15:0] base_of;
    input [7:0] hi;
    input [7:0] lo;
    begin
      base_of = {hi, lo[7:3], 3'b000};
    end
  endfunction

  assign internal_dma_request_one_sel = dma_sel(shm, dma_ff[2:0]);
  assign internal_dma_request_two_sel = dma_sel(shm, dma_ff[6:4]);
  assign mem_window_hit = shm && ctl_ff[`IRCC_WIN_BIT] &&
    (host_mem_addr[19:13] == wbase_ff[7:1]);
  assign uart_base_addr = base_of(uh_ff, ul_ff);
  assign fast_base_addr = base_of(fh_ff, fl_ff);

  // Interrupt routing
  function [3:0] route;
    input [2:0] sel;
    input req;
    begin
      route = 4'h0;
      case (sel)
        `IRCC_SEL_IRQ3: route[0] = req;
        `IRCC_SEL_IRQ4: route[1] = req;
        `IRCC_SEL_UPIN: route[2] = req;
        `IRCC_SEL_FPIN: route[3] = req;
        default: route = 4'h0;
      endcase
    end
  endfunction

  wire adv = ctl_ff[`IRCC_ADV_BIT];
  wire shsel = ctl_ff[`IRCC_SHSEL_BIT];
  wire shared_req = uart_req || fast_req;
  // Order: irq3, irq4, uart pin, infrared pin
  wire [3:0] adv_lines = route(ul_ff[2:0], uart_req) |
    route(fl_ff[2:0], fast_req);
  wire [3:0] fix_lines = {fast_req, uart_req, shsel & shared_req, !shsel & shared_req};
  // Mode changes while a request stands may give one extra pulse
  wire [3:0] lines = adv ? adv_lines : fix_lines;
  wire level_mode = adv && ctl_ff[`IRCC_LVL_BIT];
  wire [3:0] pulses;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pin
      ircc_pulse #(.CNT_W(16), .PULSE_CYC(PULSE_CYC)) u_pulse (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .req(lines[g]),
        .pulse(pulses[g])
      );
    end
  endgenerate
  reg [3:0] irq_n_ff;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      irq_n_ff <= 4'hf;
    else
      irq_n_ff <= level_mode ? ~lines : ~pulses;
  end
  assign irq_out_n = irq_n_ff;
  assign uart_interrupt_pin = irq_n_ff[2];
  assign infrared_interrupt_pin = irq_n_ff[3];

  // Read channel, answer one cycle after address
  // Data are captured at the handshake so they stand until taken
  wire [7:0] ar_idx = idx_of(s_axi_araddr);
  wire ar_ok = (s_axi_araddr[11:10] == 2'b00) && known_idx(ar_idx);
  assign s_axi_arready = !rvalid_ff;
  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    case (ar_idx)
      `IRCC_IDX_PWR: rd_val = pwr_ff;
      `IRCC_IDX_ID: rd_val = shm ? ID_SHM : ID_DMA;
      `IRCC_IDX_DMA: rd_val = shm ? wbase_ff : dma_ff;
      `IRCC_IDX_CTL: rd_val = ctl_ff;
      `IRCC_IDX_UH: rd_val = uh_ff;
      `IRCC_IDX_UL: rd_val = ul_ff;
      `IRCC_IDX_FH: rd_val = fh_ff;
      `IRCC_IDX_FL: rd_val = fl_ff;
      `IRCC_IDX_STAT: rd_val = {2'b00, shm, transceiver_off_output, power_down, ~irq_n_ff[2:0]};
      default: rd_val = 8'h00;
    endcase
  end
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_ff <= 1'b0;
      rerr_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rerr_ff <= !ar_ok;
      rdata_ff <= ar_ok ? rd_val : 8'h00;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = {24'h000000, rdata_ff};
  assign s_axi_rresp = rerr_ff ? `IRCC_RESP_SLVERR : `IRCC_RESP_OKAY;
endmodule

// [ircc_cfg_monitor.sv]
`timescale 1ns/1ps
module ircc_cfg_monitor (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] irq_out_n,
  input wire logic [2:0] internal_dma_request_one_sel,
  input wire logic [2:0] internal_dma_request_two_sel,
  input wire logic mem_window_hit,
  input wire logic [15:0] uart_base_addr,
  input wire logic [15:0] fast_base_addr,
  input wire logic fast_clk_en,
  input wire logic transceiver_off_output
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  uart_base_a: assert property (uart_base_addr[2:0] == 3'h0)
    else $error("uart base low bits");
  fast_base_a: assert property (fast_base_addr[2:0] == 3'h0)
    else $error("fast infrared base low bits");
  win_mode_a: assert property (
    mem_window_hit |-> internal_dma_request_one_sel == 3'h4 &&
    internal_dma_request_two_sel == 3'h4) else $error("window hit outside shared mode");
  core_off_a: assert property (transceiver_off_output |-> !fast_clk_en)
    else $error("core clock runs while off");
  cover property (mem_window_hit);
  cover property ($fell(irq_out_n[1]));
  cover property (s_axi_bvalid && s_axi_bready);
endmodule

// [ircc_far_model.sv]
`timescale 1ns/1ps
module ircc_far_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [1:0] go,
  input wire logic pd_go,
  input wire logic shm_go,
  output logic uart_irq_req,
  output logic fast_irq_req,
  output logic power_down_input_n,
  output logic shared_memory_mode
);
  // Everything moves on an edge, as the real subsystems and straps would
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {uart_irq_req, fast_irq_req, shared_memory_mode} <= 3'h0;
      power_down_input_n <= 1'b1;
    end else begin
      {fast_irq_req, uart_irq_req} <= go;
      power_down_input_n <= !pd_go;
      shared_memory_mode <= shm_go;
    end
  end
endmodule

// [tb_ircc_cfg.sv]
`timescale 1ns/1ps
`include "ircc_regs.vh"
module tb_ircc_cfg;
  localparam [7:0] ID_D = 8'h3c; // Arbitrary identity values
  localparam [7:0] ID_S = 8'h3d;
  logic sys_clk = 0, rstn = 0, pd_go = 0, shm_go = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rdv;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [1:0] go = 0, rsp;
  logic [19:0] host_mem_addr = 0;
  logic [3:0] sn;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire shared_memory_mode, power_down_input_n, uart_irq_req, fast_irq_req;
  wire uart_clk_en, uart_interrupt_pin, infrared_interrupt_pin;
  wire [3:0] irq_out_n;
  wire [2:0] internal_dma_request_one_sel, internal_dma_request_two_sel;
  wire mem_window_hit, power_down, fast_clk_en, transceiver_off_output;
  wire [15:0] uart_base_addr, fast_base_addr;
  int miscompares = 0, checks_done = 0, len;
  ircc_cfg #(.ID_DMA(ID_D), .ID_SHM(ID_S)) dut (.sys_clk, .rstn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .shared_memory_mode, .power_down_input_n, .uart_irq_req, .fast_irq_req, .host_mem_addr,
    .irq_out_n, .uart_interrupt_pin, .infrared_interrupt_pin,
    .internal_dma_request_one_sel, .internal_dma_request_two_sel, .mem_window_hit,
    .uart_base_addr, .fast_base_addr, .power_down, .uart_clk_en, .fast_clk_en,
    .transceiver_off_output);
  ircc_far_model far (.sys_clk, .rstn, .go, .pd_go, .shm_go, .uart_irq_req, .fast_irq_req,
    .power_down_input_n, .shared_memory_mode);
  initial forever #50 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      miscompares++;
      end_of_test();
    end
  endtask
  // Address and data are offered together; each is released once taken
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    int n;
    bit a, w;
    n = 0;
    a = 0;
    w = 0;
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(a && w) && n < 200) begin
      @(posedge sys_clk);
      n++;
      if (!a && s_axi_awready) begin
        a = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    while (!s_axi_bvalid && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] i);
    int n;
    n = 0;
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!s_axi_arready && n < 200);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
    tmo(n);
  endtask
  // Pulse length is counted in whole cycles, so it is good to one cycle only
  task automatic pulse(input int b);
    int n;
    n = 0;
    while (irq_out_n[b] !== 1'b0 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    tmo(n);
    len = 0;
    while (irq_out_n[b] === 1'b0 && len < 12000) begin
      @(posedge sys_clk);
      len++;
      if (len == 10) sn = irq_out_n;
    end
  endtask
  initial begin
    cyc(4);
    rstn <= 1;
    rd(`IRCC_IDX_PWR);
    chk(rdv, 32'h2);
    chk(uart_clk_en, 1'b0);
    wr(`IRCC_IDX_ID, 8'hff);
    rd(`IRCC_IDX_ID);
    chk(rdv, ID_D);
    rd(8'h10);
    chk(rsp, `IRCC_RESP_SLVERR);
    wr(8'h10, 8'h00);
    chk(rsp, `IRCC_RESP_SLVERR);
    wr(`IRCC_IDX_DMA, 8'h31);
    chk(internal_dma_request_two_sel, 3'h3);
    chk(internal_dma_request_one_sel, 3'h1);
    wr(`IRCC_IDX_UH, 8'h12);
    wr(`IRCC_IDX_UL, 8'hab);
    chk(uart_base_addr, 16'h12a8);
    chk(uart_clk_en, 1'b1);
    wr(`IRCC_IDX_FH, 8'h34);
    wr(`IRCC_IDX_FL, 8'h5b);
    chk(fast_base_addr, 16'h3458);
    wr(`IRCC_IDX_PWR, 8'h00);
    wr(`IRCC_IDX_PWR, 8'h01);
    chk(power_down, 1'b0);
    wr(`IRCC_IDX_CTL, 8'h00);
    chk(transceiver_off_output, 1'b1);
    wr(`IRCC_IDX_CTL, 8'h01);
    chk(transceiver_off_output, 1'b0);
    chk(fast_clk_en, 1'b1);
    wr(`IRCC_IDX_PWR, 8'h02);
    wr(`IRCC_IDX_PWR, 8'h03);
    chk(power_down, 1'b1);
    chk(fast_clk_en, 1'b0);
    chk(uart_clk_en, 1'b0);
    wr(`IRCC_IDX_PWR, 8'h02);
    pd_go <= 1;
    cyc(6);
    chk(power_down, 1'b1);
    pd_go <= 0;
    wr(`IRCC_IDX_CTL, 8'h11);
    go <= 2'b01;
    pulse(2);
    chk(len >= 5000 && len <= 10000, 1);
    chk(sn, 4'b1010);
    go <= 0;
    wr(`IRCC_IDX_CTL, 8'h15);
    go <= 2'b10;
    pulse(3);
    chk(sn, 4'b0101);
    go <= 0;
    wr(`IRCC_IDX_CTL, 8'h19);
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 5; c++) begin
        wr(s ? `IRCC_IDX_FL : `IRCC_IDX_UL, (s ? 8'h58 : 8'ha8) | c[7:0]);
        go[s] <= 1;
        cyc(8);
        chk(irq_out_n, c < 4 ? {28'h0, ~(4'h1 << c[1:0])} : 32'hf);
        chk({infrared_interrupt_pin, uart_interrupt_pin}, {c != 3, c != 2});
        go <= 0;
        cyc(8);
        chk(irq_out_n, 4'hf);
      end
    wr(`IRCC_IDX_CTL, 8'h1d);
    wr(`IRCC_IDX_UL, 8'ha9);
    wr(`IRCC_IDX_FL, 8'h59);
    go <= 2'b11;
    cyc(8);
    chk(irq_out_n, 4'hd);
    go <= 2'b10;
    cyc(20);
    chk(irq_out_n, 4'hd);
    go <= 0;
    shm_go <= 1;
    cyc(4);
    rd(`IRCC_IDX_ID);
    chk(rdv, ID_S);
    wr(`IRCC_IDX_DMA, 8'hc2);
    wr(`IRCC_IDX_CTL, 8'h21);
    host_mem_addr <= {7'h61, 13'h0abc};
    cyc(2);
    chk(mem_window_hit, 1'b1);
    host_mem_addr <= 20'h0;
    cyc(2);
    chk(mem_window_hit, 1'b0);
    host_mem_addr <= {7'h61, 13'h0};
    wr(`IRCC_IDX_CTL, 8'h01);
    chk(mem_window_hit, 1'b0);
    wr(`IRCC_IDX_PWR, 8'h42);
    wr(`IRCC_IDX_UH, 8'hff);
    chk(uart_base_addr, 16'h12a8);
    chk(rsp, `IRCC_RESP_OKAY);
    end_of_test();
  end
endmodule
bind ircc_cfg ircc_cfg_monitor mon (.sys_clk, .rstn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_out_n, .internal_dma_request_one_sel,
  .internal_dma_request_two_sel, .mem_window_hit, .uart_base_addr, .fast_base_addr,
  .fast_clk_en, .transceiver_off_output);
